// *** hw/power_monitor_defs.vh ***
// offsets and field positions of the result and alert registers, and the reset value of the diag register
`ifndef POWER_MONITOR_DEFS_VH
`define POWER_MONITOR_DEFS_VH
`define ADDR_BUS_VOLTAGE_RESULT 8'h05
`define ADDR_DIE_TEMPERATURE_RESULT 8'h06
`define ADDR_CURRENT_RESULT 8'h07
`define ADDR_POWER_RESULT 8'h08
`define ADDR_DIAGNOSTIC_ALERT_FLAGS 8'h0b
`define DIAG_RESET 16'h0001
`define BIT_ALERT_LATCH_ENABLE 15
`define BIT_CONVERSION_READY_ALERT_ENABLE 14
`define BIT_AVERAGED_COMPARE_SELECT 13
`define BIT_ALERT_POLARITY 12
`define BIT_MATH_OVERFLOW_FLAG 9
`define BIT_TEMP_OVERLIMIT_FLAG 7
`define BIT_SHUNT_OVERLIMIT_FLAG 6
`define BIT_SHUNT_UNDERLIMIT_FLAG 5
`define BIT_BUS_OVERLIMIT_FLAG 4
`define BIT_BUS_UNDERLIMIT_FLAG 3
`define BIT_POWER_OVERLIMIT_FLAG 2
`define BIT_CONVERSION_DONE_FLAG 1
`define BIT_TRIM_CHECKSUM_OK 0
`define LIMIT_FLAG_LOW 2
`define TEMP_RESERVED_LOW 4
`endif

// *** hw/limit_flag.v ***
// one limit flag, transparent or latched until a read
`timescale 1ns/10ps
`default_nettype none
module limit_flag (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // control
   input wire latch_mode,
   input wire update,
   input wire fault,
   input wire read_clear,
   // state
   output reg flag
);
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (update && fault) begin
         // set wins over a clear in the same cycle
         flag <= 1'b1;
      end else if (!latch_mode && update) begin
         // transparent: drops once the fault is gone
         flag <= 1'b0;
      end else if (latch_mode && read_clear) begin
         flag <= 1'b0;
      end
   end
endmodule // limit_flag
`default_nettype wire

// *** hw/result_hold.v ***
// result word captured on its converter strobe
`timescale 1ns/10ps
`default_nettype none
module result_hold #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // capture
   input wire load,
   input wire [WIDTH-1:0] value,
   output reg [WIDTH-1:0] held
);
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         held <= {WIDTH{1'b0}};
      end else if (load) begin
         held <= value;
      end
   end
endmodule // result_hold
`default_nettype wire

// *** hw/power_monitor_result_alert_regs.v ***
// result registers and diagnostic/alert register of the power monitor
`timescale 1ns/10ps
`default_nettype none
`include "power_monitor_defs.vh"
module power_monitor_result_alert_regs (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // register port from the serial interface
   input wire [7:0] reg_addr,
   input wire reg_write,
   input wire [15:0] reg_wdata,
   input wire reg_read_done,
   output reg [23:0] reg_rdata,
   // converter results
   input wire bus_voltage_strobe,
   input wire [15:0] bus_voltage_value,
   input wire temperature_strobe,
   input wire [11:0] temperature_value,
   input wire calc_strobe,
   input wire [15:0] current_value,
   input wire [23:0] power_value,
   input wire math_overflow,
   // comparator events
   input wire raw_sample_strobe,
   input wire averaged_strobe,
   input wire temp_over,
   input wire shunt_over,
   input wire shunt_under,
   input wire bus_over,
   input wire bus_under,
   input wire power_over,
   input wire conversion_done,
   input wire triggered_start,
   input wire trim_checksum_error,
   // alert pin, open drain
   output wire alert_out,
   output wire alert_oe
);
   // decoded register accesses
   wire diag_addr;
   wire diag_write;
   wire diag_read_end;
   // captured results
   wire [15:0] bus_held;
   wire [11:0] temp_held;
   wire [15:0] current_held;
   wire [23:0] power_held;
   wire [23:0] bus_word;
   wire [23:0] temp_word;
   wire [23:0] current_word;
   // limit comparisons
   wire [5:0] faults;
   wire [5:0] limit_flags;
   wire compare_update;
   // alert
   wire limit_alert;
   wire ready_alert;
   wire alert_active;
   // diag control and status
   reg latch_mode;
   reg cnv_alert_en;
   reg avg_select;
   reg polarity;
   reg next_latch_mode;
   reg next_cnv_alert_en;
   reg next_avg_select;
   reg next_polarity;
   reg math_flag;
   reg next_math_flag;
   reg done_flag;
   reg next_done_flag;
   reg checksum_ok;
   reg next_checksum_ok;
   reg read_clear;
   reg [15:0] diag_word;
   reg [23:0] next_rdata;

   assign diag_addr = (reg_addr == `ADDR_DIAGNOSTIC_ALERT_FLAGS);
   assign diag_write = reg_write && diag_addr;
   // clear keyed to the end of the read
   assign diag_read_end = reg_read_done && diag_addr;

   // one fault line per flag, placed at its register bit
   assign faults[`BIT_TEMP_OVERLIMIT_FLAG - `LIMIT_FLAG_LOW] = temp_over;
   assign faults[`BIT_SHUNT_OVERLIMIT_FLAG - `LIMIT_FLAG_LOW] = shunt_over;
   assign faults[`BIT_SHUNT_UNDERLIMIT_FLAG - `LIMIT_FLAG_LOW] = shunt_under;
   assign faults[`BIT_BUS_OVERLIMIT_FLAG - `LIMIT_FLAG_LOW] = bus_over;
   assign faults[`BIT_BUS_UNDERLIMIT_FLAG - `LIMIT_FLAG_LOW] = bus_under;
   assign faults[`BIT_POWER_OVERLIMIT_FLAG - `LIMIT_FLAG_LOW] = power_over;

   assign compare_update = avg_select ? averaged_strobe : raw_sample_strobe;

   // bus voltage capture, sign bit forced clear
   result_hold #(
      .WIDTH(16)
   ) u_bus (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(bus_voltage_strobe),
      .value({1'b0, bus_voltage_value[14:0]}),
      .held(bus_held)
   );

   result_hold #(
      .WIDTH(12)
   ) u_temp (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(temperature_strobe),
      .value(temperature_value),
      .held(temp_held)
   );

   result_hold #(
      .WIDTH(16)
   ) u_cur (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(calc_strobe),
      .value(current_value),
      .held(current_held)
   );

   result_hold #(
      .WIDTH(24)
   ) u_pwr (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(calc_strobe),
      .value(power_value),
      .held(power_held)
   );

   // limit flags, bit 7 down to 2
   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_limit
         limit_flag u_flag (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .latch_mode(latch_mode),
            .update(compare_update),
            .fault(faults[i]),
            .read_clear(read_clear),
            .flag(limit_flags[i])
         );
      end
   endgenerate

   // clear one cycle after read completes
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         read_clear <= 1'b0;
      end else begin
         read_clear <= diag_read_end;
      end
   end

   always @* begin
      next_latch_mode = latch_mode;
      next_cnv_alert_en = cnv_alert_en;
      next_avg_select = avg_select;
      next_polarity = polarity;
      if (diag_write) begin
         // low bits are status only; host writes to them are dropped
         next_latch_mode = reg_wdata[`BIT_ALERT_LATCH_ENABLE];
         next_cnv_alert_en = reg_wdata[`BIT_CONVERSION_READY_ALERT_ENABLE];
         next_avg_select = reg_wdata[`BIT_AVERAGED_COMPARE_SELECT];
         next_polarity = reg_wdata[`BIT_ALERT_POLARITY];
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latch_mode <= 1'b0;
         cnv_alert_en <= 1'b0;
         avg_select <= 1'b0;
         polarity <= 1'b0;
      end else begin
         latch_mode <= next_latch_mode;
         cnv_alert_en <= next_cnv_alert_en;
         avg_select <= next_avg_select;
         polarity <= next_polarity;
      end
   end

   always @* begin
      next_math_flag = math_flag;
      if (calc_strobe && math_overflow) begin
         // a new overflow outranks a trigger in the same cycle
         next_math_flag = 1'b1;
      end else if (triggered_start) begin
         next_math_flag = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         math_flag <= 1'b0;
      end else begin
         math_flag <= next_math_flag;
      end
   end

   always @* begin
      next_done_flag = done_flag;
      if (conversion_done) begin
         next_done_flag = 1'b1;
      end else if (!latch_mode) begin
         // transparent: a pulse-long indication, dropped next cycle
         next_done_flag = 1'b0;
      end else if (read_clear || triggered_start) begin
         next_done_flag = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done_flag <= 1'b0;
      end else begin
         done_flag <= next_done_flag;
      end
   end

   // checksum status, sticky low once an error is seen
   always @* begin
      next_checksum_ok = checksum_ok;
      if (trim_checksum_error) begin
         // no way back short of reset: the trim data stays suspect
         next_checksum_ok = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         checksum_ok <= 1'b1;
      end else begin
         checksum_ok <= next_checksum_ok;
      end
   end

   always @* begin
      diag_word = 16'h0000;
      diag_word[`BIT_ALERT_LATCH_ENABLE] = latch_mode;
      diag_word[`BIT_CONVERSION_READY_ALERT_ENABLE] = cnv_alert_en;
      diag_word[`BIT_AVERAGED_COMPARE_SELECT] = avg_select;
      diag_word[`BIT_ALERT_POLARITY] = polarity;
      diag_word[`BIT_MATH_OVERFLOW_FLAG] = math_flag;
      diag_word[`BIT_TEMP_OVERLIMIT_FLAG:`BIT_POWER_OVERLIMIT_FLAG] = limit_flags;
      diag_word[`BIT_CONVERSION_DONE_FLAG] = done_flag;
      diag_word[`BIT_TRIM_CHECKSUM_OK] = checksum_ok;
   end

   // upper byte of the 16-bit results reads zero
   assign bus_word = {8'h00, bus_held};
   // low nibble of the temperature reads zero
   assign temp_word = {8'h00, temp_held, 4'h0};
   assign current_word = {8'h00, current_held};

   // read data registered; the serial side samples it at the next edge
   always @* begin
      case (reg_addr)
         `ADDR_BUS_VOLTAGE_RESULT: next_rdata = bus_word;
         `ADDR_DIE_TEMPERATURE_RESULT: next_rdata = temp_word;
         `ADDR_CURRENT_RESULT: next_rdata = current_word;
         `ADDR_POWER_RESULT: next_rdata = power_held;
         `ADDR_DIAGNOSTIC_ALERT_FLAGS: next_rdata = {8'h00, diag_word};
         default: next_rdata = 24'h000000;
      endcase
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 24'h000000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // flags drive the alert for as long as they stand
   assign limit_alert = |limit_flags;
   // conversion ready reaches the alert only when routed
   assign ready_alert = cnv_alert_en && done_flag;
   assign alert_active = limit_alert || ready_alert;
   // open drain: active-low pulls when active, active-high pulls when idle
   assign alert_out = 1'b0;
   assign alert_oe = polarity ? !alert_active : alert_active;
endmodule // power_monitor_result_alert_regs
`default_nettype wire

// *** sim/power_monitor_props.sv ***
// assertions on the result and alert register ports
`timescale 1ns/10ps
`default_nettype none
module power_monitor_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // register port
   input wire logic reg_write,
   input wire logic reg_read_done,
   input wire logic [7:0] reg_addr,
   input wire logic [23:0] reg_rdata,
   // events and pin
   input wire logic raw_sample_strobe,
   input wire logic averaged_strobe,
   input wire logic conversion_done,
   input wire logic triggered_start,
   input wire logic calc_strobe,
   input wire logic math_overflow,
   input wire logic trim_checksum_error,
   input wire logic power_over,
   input wire logic alert_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire diag = reg_addr == 8'h0b;
   // no event may move the flags, so a changing read means an early clear
   wire quiet = !(raw_sample_strobe | averaged_strobe | conversion_done | triggered_start | calc_strobe
      | reg_write | trim_checksum_error);
   rsv_zero_a: assert property ($past(diag) |-> reg_rdata[23:16] == 8'h00 && reg_rdata[11:10] == 2'h0 && !reg_rdata[8])
      else $error("reserved bits set");
   temp_nibble_a: assert property ($past(reg_addr) == 8'h06 |-> reg_rdata[3:0] == 4'h0)
      else $error("temperature low bits set");
   bus_sign_a: assert property ($past(reg_addr) == 8'h05 |-> !reg_rdata[15])
      else $error("bus voltage negative");
   pin_low_a: assert property (alert_out == 1'b0)
      else $error("alert pin driven high");
   ovf_set_a: assert property (calc_strobe && math_overflow ##1 diag |=> reg_rdata[9])
      else $error("overflow not set");
   ovf_clear_a: assert property (triggered_start && !calc_strobe ##1 diag |=> !reg_rdata[9])
      else $error("overflow not cleared");
   done_set_a: assert property (conversion_done && !triggered_start ##1 diag |=> reg_rdata[1])
      else $error("conversion flag not set");
   chk_low_a: assert property (trim_checksum_error ##1 diag |=> !reg_rdata[0])
      else $error("checksum bit high");
   read_hold_a: assert property ((diag && quiet) [*3] ##0 reg_read_done |=> $stable(reg_rdata))
      else $error("flags cleared before read end");
   latch_clear_a: assert property (reg_read_done && diag && quiet && reg_rdata[15] ##1 (diag && quiet) [*3]
      |-> reg_rdata[7:1] == 7'h00)
      else $error("latched flags not cleared");
   cover property (reg_read_done && diag && reg_rdata[15]);
   cover property (calc_strobe && math_overflow);
   cover property (averaged_strobe && power_over);
endmodule // power_monitor_props
`default_nettype wire

// *** sim/host_reader.sv ***
// host model reading results and writing diag control
`timescale 1ns/10ps
`default_nettype none
module host_reader (
   // register port
   input wire clk_sys,
   input wire [23:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_write,
   output logic [15:0] reg_wdata,
   output logic reg_read_done
);
   initial {reg_addr, reg_write, reg_wdata, reg_read_done} = '0;
   // entered just after an edge; the settle wait lets a read clear land
   task rd(input [7:0] a, output [23:0] d);
      reg_addr = a;
      @(posedge clk_sys);
      #1 d = reg_rdata;
      reg_read_done = 1;
      @(posedge clk_sys);
      #1 reg_read_done = 0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task wr(input [15:0] w);
      {reg_addr, reg_write, reg_wdata} = {8'h0b, 1'b1, w};
      @(posedge clk_sys);
      #1 reg_write = 0;
      reg_wdata = ~w;
   endtask
endmodule // host_reader
`default_nettype wire

// *** sim/power_monitor_result_alert_regs_tb.sv ***
// self-checking bench for the result and alert registers
`timescale 1ns/10ps
`default_nettype none
module power_monitor_result_alert_regs_tb;
   logic clk_sys = 0, reset_n = 0, reg_write, reg_read_done, alert_out, alert_oe, math_overflow;
   logic bus_voltage_strobe, temperature_strobe, calc_strobe, raw_sample_strobe, averaged_strobe;
   logic conversion_done, triggered_start, trim_checksum_error;
   logic temp_over, shunt_over, shunt_under, bus_over, bus_under, power_over;
   logic [6:0] evs;
   logic [5:0] flt;
   logic [7:0] reg_addr;
   logic [11:0] temperature_value;
   logic [15:0] reg_wdata, bus_voltage_value, current_value, bv, tp, cu, d;
   logic [23:0] reg_rdata, power_value, pw, got;
   int errors = 0, num_checks = 0, seed = 32'h7dd5cca3, i, k;
   assign {bus_voltage_strobe, temperature_strobe, raw_sample_strobe, averaged_strobe, conversion_done,
      triggered_start, calc_strobe} = evs;
   assign {temp_over, shunt_over, shunt_under, bus_over, bus_under, power_over} = flt;
   power_monitor_result_alert_regs i_dut (.*);
   host_reader i_host (.*);
   always #5 clk_sys = ~clk_sys;
   task ck(input [23:0] g, e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   function [23:0] exp_of(input [7:0] a);
      case (a)
         8'h05: exp_of = bv;
         8'h06: exp_of = tp;
         8'h07: exp_of = cu;
         8'h08: exp_of = pw;
         8'h0b: exp_of = d;
         default: exp_of = 0;
      endcase
   endfunction
   task chk(input [7:0] a);
      i_host.rd(a, got);
      ck(got, exp_of(a));
      if (a == 8'h0b && d[15]) d[7:1] = 0;
   endtask
   task pin;
      ck({alert_out, alert_oe}, {1'b0, d[12] ^ (|d[7:2] | d[14] & d[1])});
   endtask
   task ev(input [6:0] e);
      evs = e;
      @(posedge clk_sys);
      #1 evs = 0;
      // an idle edge keeps two strobes from being set in one time step
      @(posedge clk_sys);
      #1;
   endtask
   // flags follow the selected strobe only; latched mode accumulates
   task fault(input [5:0] f, input avg);
      flt = f;
      ev(avg ? 7'h08 : 7'h10);
      if (avg == d[13]) d[7:2] = d[15] ? d[7:2] | f : f;
   endtask
   task results;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #300000 errors++;
      results;
   end
   initial begin
      {evs, flt, math_overflow, trim_checksum_error, temperature_value} = 0;
      {bus_voltage_value, current_value, power_value, bv, tp, cu, pw} = 0;
      d = 16'h0001;
      repeat (16) @(posedge clk_sys);
      #1 reset_n = 1;
      for (k = 5; k < 12; k++) chk(k[7:0]);
      for (i = 0; i < 5; i++) begin
         k = $random(seed);
         {bus_voltage_value, current_value} = k;
         k = $random(seed);
         {temperature_value, power_value} = {k[31:20], k[23:0]};
         if (i == 0) {bus_voltage_value, temperature_value} = {16'hffff, 12'h800};
         ev(7'h61);
         {bv, tp, cu, pw} = {1'b0, bus_voltage_value[14:0], temperature_value, 4'h0, current_value, power_value};
         for (k = 5; k < 9; k++) chk(k[7:0]);
      end
      for (i = 0; i < 8; i++) begin
         k = $random(seed);
         i_host.wr({i[2], 1'b0, i[1:0], k[11:0]});
         d[15:12] = {i[2], 1'b0, i[1:0]};
         repeat (2) begin
            k = $random(seed);
            fault(k[5:0], k[6]);
            pin;
         end
         chk(8'h0b);
         fault(6'h00, i[1]);
         pin;
      end
      i_host.wr(16'h8000);
      d[15:12] = 4'h8;
      ev(7'h04);
      d[1] = 1;
      pin;
      i_host.wr(16'hc000);
      d[14] = 1;
      pin;
      ev(7'h02);
      d[1] = 0;
      pin;
      math_overflow = 1;
      ev(7'h05);
      {d[9], d[1], math_overflow} = 3'b110;
      chk(8'h0b);
      chk(8'h0b);
      ev(7'h02);
      d[9] = 0;
      chk(8'h0b);
      trim_checksum_error = 1;
      ev(7'h00);
      {trim_checksum_error, d[0]} = 0;
      chk(8'h0b);
      results;
   end
endmodule // power_monitor_result_alert_regs_tb
bind power_monitor_result_alert_regs power_monitor_props i_props (.*);
`default_nettype wire
